// ---- include/dac_front_pkg.sv ----
package dac_front_pkg;

  // ==========================================================
  // Frame and channel geometry
  localparam int FRAME_BITS = 24;
  localparam int NUM_CH     = 8;
  localparam int CODE_W     = 16;
  localparam int CNT_W      = 5;
  localparam int FIFO_DEPTH = 8;
  localparam logic [CNT_W-1:0] LAST_BIT = 5'h17;
  localparam logic [CNT_W-1:0] FULL_CNT = 5'h18;

  // ==========================================================
  // Frame fields
  localparam int CMD_MSB  = 23;
  localparam int CMD_LSB  = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;

  // ==========================================================
  // Command codes
  localparam logic [3:0] CMD_WRITE_IN   = 4'h1;
  localparam logic [3:0] CMD_LOAD_MASK  = 4'h2;
  localparam logic [3:0] CMD_WRITE_LOAD = 4'h3;
  localparam logic [3:0] CMD_READBACK   = 4'h9;
  localparam logic [3:0] CMD_DAISY      = 4'hF;

  // ==========================================================
  // Reset codes
  localparam logic [15:0] ZERO_CODE = 16'h0000;
  localparam logic [15:0] MID_CODE  = 16'h8000;

  // ==========================================================
  // Serial clock timing
  localparam int REF_CLK_MHZ    = 250;
  localparam int SCLK_MAX_MHZ   = 50;
  localparam int SCLK_MIN_CYCLES = (REF_CLK_MHZ + SCLK_MAX_MHZ - 1)
                                   / SCLK_MAX_MHZ;

  // ==========================================================
  // Synchronised pin positions
  localparam int PIN_SCLK  = 0;
  localparam int PIN_SYNC  = 1;
  localparam int PIN_SDI   = 2;
  localparam int PIN_LOAD  = 3;
  localparam int PIN_RST   = 4;
  localparam int PIN_STRAP = 5;
  localparam int PIN_W     = 6;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [3:0]  cmd;
    logic [3:0]  addr;
    logic [15:0] data;
  } frame_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_SHIFT = 2'b01,
    RX_DONE  = 2'b10
  } rx_state_t;

endpackage : dac_front_pkg

// ---- core/frame_fifo.sv ----
`timescale 1ns/1ns
module frame_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // ==========================================================
  // Status
  assign empty     = (wr_ptr_q == rd_ptr_q);
  assign full      = (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]) &&
                     (wr_ptr_q[AW] != rd_ptr_q[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_q[AW-1:0]];
  assign push      = clk_en && in_valid && !full;
  assign pop       = clk_en && out_ready && !empty;

  // ==========================================================
  // Storage
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  // ==========================================================
  // Pointers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule : frame_fifo

// ---- core/dac_serial_front.sv ----
`timescale 1ns/1ns
// Operation
// [RQ1] After frame sync falls, take bits on the next 24 falling clocks.
// [RQ2] Sample data on each falling serial clock, up to 50 MHz.
// [RQ3] The input shift register holds exactly 24 bits per frame.
// [RQ4] Load pulse low copies pending input codes into output codes together.
// [RQ5] Load works by pulse or held low; low makes writes update at once.
// [RQ6] Output bits launch on rising serial clock; receiver takes them falling.
// [RQ7] Serial output carries readback data or shifted-through bits for chains.
// [RQ8] A falling edge on the reset pin starts a reset.
// [RQ9] While the reset pin stays low, further reset pulses are ignored.
// [RQ10] Reset loads input and output codes with the strap-chosen level.
// [RQ11] Strap low gives zero scale, strap high gives midscale.
// [RQ12] Zero scale is 0x0000 and midscale is 0x8000 for every channel.
module dac_serial_front #(
  parameter int NUM_CH     = dac_front_pkg::NUM_CH,
  parameter int CODE_W     = dac_front_pkg::CODE_W,
  parameter int FIFO_DEPTH = dac_front_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           rst_b,
  input  wire logic                           clk_en,
  // Serial link
  input  wire logic                           sclk,
  input  wire logic                           sync_n,
  input  wire logic                           sdi,
  output logic                                sdo,
  // Control pins
  input  wire logic                           load_outputs_n,
  input  wire logic                           hw_reset_n,
  input  wire logic                           reset_level_strap,
  // Status
  output logic                                frame_ready,
  output logic                                daisy_mode,
  output logic [NUM_CH-1:0][CODE_W-1:0]       input_code,
  output logic [NUM_CH-1:0][CODE_W-1:0]       dac_code
);

  localparam int PW = dac_front_pkg::PIN_W;
  localparam int FB = dac_front_pkg::FRAME_BITS;

  logic [PW-1:0]                 pin_meta_q;
  logic [PW-1:0]                 pin_q;
  logic                          sclk_prev_q;
  logic                          sync_prev_q;
  logic                          load_prev_q;
  logic                          rst_prev_q;
  logic                          sclk_fall;
  logic                          sclk_rise;
  logic                          sync_fall;
  logic                          sync_rise;
  logic                          load_fall;
  logic                          reset_go;
  logic                          init_q;
  dac_front_pkg::rx_state_t      rx_q;
  logic [FB-1:0]                 sr_q;
  logic [dac_front_pkg::CNT_W-1:0] cnt_q;
  logic [FB-1:0]                 tx_q;
  logic                          sdo_q;
  logic                          push;
  logic                          fifo_ready;
  logic                          exec_valid;
  logic                          exec_ready;
  logic                          exec;
  dac_front_pkg::frame_t         push_frame;
  dac_front_pkg::frame_t         cur;
  logic [FB-1:0]                 cur_bits;
  logic [NUM_CH-1:0][CODE_W-1:0] in_code_q;
  logic [NUM_CH-1:0][CODE_W-1:0] dac_code_q;
  logic [NUM_CH-1:0]             pend_q;
  logic                          daisy_q;
  logic                          rb_arm_q;
  logic [3:0]                    rb_ch_q;
  logic [CODE_W-1:0]             rst_val;
  logic                          write_cmd;
  logic                          load_cmd;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_q <= 6'h1B;
      pin_q      <= 6'h1B;
    end else if (clk_en) begin
      pin_meta_q <= {reset_level_strap, hw_reset_n, load_outputs_n,
                     sdi, sync_n, sclk};
      pin_q      <= pin_meta_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev_q <= 1'b1;
      sync_prev_q <= 1'b1;
      load_prev_q <= 1'b1;
      rst_prev_q  <= 1'b1;
    end else if (clk_en) begin
      sclk_prev_q <= pin_q[dac_front_pkg::PIN_SCLK];
      sync_prev_q <= pin_q[dac_front_pkg::PIN_SYNC];
      load_prev_q <= pin_q[dac_front_pkg::PIN_LOAD];
      rst_prev_q  <= pin_q[dac_front_pkg::PIN_RST];
    end
  end

  // ==========================================================
  // Edge detection
  // [RQ2] falling-edge sampling
  assign sclk_fall = clk_en && sclk_prev_q &&
                     !pin_q[dac_front_pkg::PIN_SCLK];
  assign sclk_rise = clk_en && !sclk_prev_q &&
                     pin_q[dac_front_pkg::PIN_SCLK];
  assign sync_fall = clk_en && sync_prev_q &&
                     !pin_q[dac_front_pkg::PIN_SYNC];
  assign sync_rise = clk_en && !sync_prev_q &&
                     pin_q[dac_front_pkg::PIN_SYNC];
  assign load_fall = clk_en && load_prev_q &&
                     !pin_q[dac_front_pkg::PIN_LOAD];
  // [RQ8] [RQ9] falling edge only, plus the power-up init_q pulse
  assign reset_go  = clk_en && (init_q || (rst_prev_q &&
                     !pin_q[dac_front_pkg::PIN_RST]));
  // [RQ11] [RQ12] strap level
  assign rst_val   = pin_q[dac_front_pkg::PIN_STRAP] ?
                     dac_front_pkg::MID_CODE : dac_front_pkg::ZERO_CODE;

  // ==========================================================
  // Receive state machine
  // [RQ1] 24 falling clocks
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_q  <= dac_front_pkg::RX_IDLE;
      cnt_q <= '0;
    end else if (clk_en) begin
      case (rx_q)
        dac_front_pkg::RX_IDLE: begin
          cnt_q <= '0;
          if (sync_fall) begin
            rx_q <= dac_front_pkg::RX_SHIFT;
          end
        end
        dac_front_pkg::RX_SHIFT: begin
          if (sync_rise) begin
            rx_q <= dac_front_pkg::RX_IDLE;
          end else if (sclk_fall) begin
            if (cnt_q == dac_front_pkg::LAST_BIT) begin
              cnt_q <= dac_front_pkg::FULL_CNT;
              if (!daisy_q) begin
                rx_q <= dac_front_pkg::RX_DONE;
              end
            end else if (cnt_q != dac_front_pkg::FULL_CNT) begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        dac_front_pkg::RX_DONE: begin
          if (sync_rise) begin
            rx_q <= dac_front_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_q <= dac_front_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // [RQ3] 24-bit shift register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sr_q <= '0;
    end else if (sclk_fall && rx_q == dac_front_pkg::RX_SHIFT) begin
      sr_q <= {sr_q[FB-2:0], pin_q[dac_front_pkg::PIN_SDI]};
    end
  end

  // Normal frames complete on the 24th bit, chained ones at sync rise
  assign push = (!daisy_q && sclk_fall && !sync_rise &&
                 rx_q == dac_front_pkg::RX_SHIFT &&
                 cnt_q == dac_front_pkg::LAST_BIT) ||
                (daisy_q && sync_rise &&
                 rx_q == dac_front_pkg::RX_SHIFT &&
                 cnt_q == dac_front_pkg::FULL_CNT);
  assign push_frame = daisy_q ? sr_q :
                      {sr_q[FB-2:0], pin_q[dac_front_pkg::PIN_SDI]};

  // ==========================================================
  // Frame queue
  frame_fifo #(
    .WIDTH (FB),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .clk_en    (clk_en),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_frame),
    .out_valid (exec_valid),
    .out_ready (exec_ready),
    .out_data  (cur_bits)
  );

  // Commands wait while the reset pin is held low
  assign exec_ready = pin_q[dac_front_pkg::PIN_RST] && !init_q;
  assign exec       = clk_en && exec_valid && exec_ready && !reset_go;
  assign cur        = cur_bits;
  assign write_cmd  = (cur.cmd == dac_front_pkg::CMD_WRITE_IN) ||
                      (cur.cmd == dac_front_pkg::CMD_WRITE_LOAD);
  assign load_cmd   = (cur.cmd == dac_front_pkg::CMD_LOAD_MASK);

  // ==========================================================
  // Power-up initialisation
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      init_q <= 1'b1;
    end else if (clk_en) begin
      init_q <= 1'b0;
    end
  end

  // ==========================================================
  // Channel registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_code_q  <= '0;
      dac_code_q <= '0;
      pend_q     <= '0;
    end else if (reset_go) begin
      // [RQ10] reset both register sets
      for (int i = 0; i < NUM_CH; i++) begin
        in_code_q[i]  <= rst_val;
        dac_code_q[i] <= rst_val;
      end
      pend_q <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < NUM_CH; i++) begin
        // [RQ4] load pulse copies pending
        if (load_fall && pend_q[i]) begin
          dac_code_q[i] <= in_code_q[i];
          pend_q[i]     <= 1'b0;
        end
        if (exec && load_cmd && cur.data[i]) begin
          dac_code_q[i] <= in_code_q[i];
          pend_q[i]     <= 1'b0;
        end
        if (exec && write_cmd && cur.addr == 4'(i)) begin
          in_code_q[i] <= cur.data;
          // [RQ5] load held low updates at once
          if (cur.cmd == dac_front_pkg::CMD_WRITE_LOAD ||
              !pin_q[dac_front_pkg::PIN_LOAD]) begin
            dac_code_q[i] <= cur.data;
            pend_q[i]     <= 1'b0;
          end else begin
            pend_q[i]     <= 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // Readback and chain configuration
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      daisy_q  <= 1'b0;
      rb_arm_q <= 1'b0;
      rb_ch_q  <= '0;
    end else if (reset_go) begin
      daisy_q  <= 1'b0;
      rb_arm_q <= 1'b0;
    end else if (clk_en) begin
      if (exec && cur.cmd == dac_front_pkg::CMD_DAISY) begin
        daisy_q <= cur.data[0];
      end
      if (exec && cur.cmd == dac_front_pkg::CMD_READBACK) begin
        rb_arm_q <= 1'b1;
        rb_ch_q  <= cur.addr;
      end else if (sync_fall) begin
        rb_arm_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Serial output
  // [RQ6] [RQ7] launch on rising clock
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_q  <= '0;
      sdo_q <= 1'b0;
    end else if (sync_fall) begin
      tx_q  <= '0;
      sdo_q <= 1'b0;
      if (rb_arm_q && !daisy_q && rb_ch_q < 4'(NUM_CH)) begin
        tx_q  <= {in_code_q[rb_ch_q[2:0]], 8'h00};
        sdo_q <= 1'b0;
      end
    end else if (sclk_rise) begin
      sdo_q <= daisy_q ? sr_q[FB-1] : tx_q[FB-1];
      tx_q  <= {tx_q[FB-2:0], 1'b0};
    end
  end

  assign sdo         = sdo_q;
  assign frame_ready = fifo_ready;
  assign daisy_mode  = daisy_q;
  assign input_code  = in_code_q;
  assign dac_code    = dac_code_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_last_bit;
    sclk_fall && !daisy_q && rx_q == dac_front_pkg::RX_SHIFT &&
    cnt_q == dac_front_pkg::LAST_BIT && !sync_rise;
  endsequence

  sequence s_load_ch0;
    load_fall && pend_q[0] && !reset_go && !exec;
  endsequence

  a_frame_bits_count: assert property ( // [RQ1]
    push && !daisy_q |-> cnt_q == dac_front_pkg::LAST_BIT)
    else $error("frame pushed before 24 bits");

  a_sample_on_fall: assert property ( // [RQ2]
    rx_q == dac_front_pkg::RX_SHIFT && !sclk_fall && clk_en
    |=> sr_q == $past(sr_q))
    else $error("shift register moved without falling clock");

  a_frame_word: assert property ( // [RQ3]
    s_last_bit |-> push && push_frame ==
      {sr_q[FB-2:0], pin_q[dac_front_pkg::PIN_SDI]})
    else $error("24-bit frame not formed");

  a_load_pulse_copy: assert property ( // [RQ4]
    s_load_ch0 |=> dac_code_q[0] == in_code_q[0] && !pend_q[0])
    else $error("load pulse did not copy pending code");

  a_load_low_write: assert property ( // [RQ5]
    exec && write_cmd && cur.addr == 4'h0 &&
    !pin_q[dac_front_pkg::PIN_LOAD]
    |=> dac_code_q[0] == $past(cur.data))
    else $error("write with load low did not update");

  a_sdo_launch: assert property ( // [RQ6]
    $changed(sdo_q) |-> $past(sclk_rise) || $past(sync_fall))
    else $error("serial output changed off rising clock");

  a_daisy_through: assert property ( // [RQ7]
    daisy_q && sclk_rise && !sync_fall |=> sdo_q == $past(sr_q[FB-1]))
    else $error("chained bit not passed through");

  a_reset_edge_only: assert property ( // [RQ8]
    reset_go && !init_q |-> rst_prev_q)
    else $error("reset started without falling edge");

  a_reset_held_ignore: assert property ( // [RQ9]
    !rst_prev_q && !init_q |-> !reset_go)
    else $error("reset retriggered while held low");

  a_reset_level: assert property ( // [RQ10]
    reset_go |=> in_code_q[NUM_CH-1] == $past(rst_val) &&
      dac_code_q[0] == $past(rst_val) && pend_q == '0)
    else $error("reset did not load strap level");

  a_strap_mid_zero: assert property ( // [RQ11]
    reset_go ##1 1 |-> dac_code_q[0] ==
      ($past(pin_q[dac_front_pkg::PIN_STRAP]) ?
       dac_front_pkg::MID_CODE : dac_front_pkg::ZERO_CODE))
    else $error("strap level mismatch");

  a_reset_codes: assert property ( // [RQ12]
    reset_go ##1 1 |-> in_code_q[0] ==
      {$past(pin_q[dac_front_pkg::PIN_STRAP]), 15'h0000})
    else $error("reset code not zero or midscale");

endmodule : dac_serial_front

// ---- dv/spi_host_model.sv ----
`timescale 1ns/1ns
// ==========================================
// Host serial master
module spi_host_model (
  // Clock
  input  wire logic ref_clk,
  // Serial link
  output logic      sclk,
  output logic      sync_n,
  output logic      sdi,
  input  wire logic sdo
);
  localparam int HALF = 80;
  initial begin
    sclk   = 1'b0;
    sync_n = 1'b1;
    sdi    = 1'b0;
  end
  // Launch on rise, capture on fall
  task automatic bit_io(input logic b, output logic r);
    sclk = 1'b1;
    sdi  = b;
    #HALF;
    r    = sdo;
    sclk = 1'b0;
    #HALF;
  endtask : bit_io
  task automatic open_frame();
    @(posedge ref_clk);
    #1;
    sync_n = 1'b0;
    #HALF;
  endtask : open_frame
  // Released data line shows the inverse value
  task automatic close_frame();
    sync_n = 1'b1;
    sdi    = ~sdi;
    #HALF;
  endtask : close_frame
  // Bits on the clocks after frame sync falls
  task automatic xfer24(input logic [23:0] tx, output logic [23:0] rx);
    open_frame();
    for (int i = 23; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    close_frame();
  endtask : xfer24
  task automatic xfer48(input logic [47:0] tx, output logic [47:0] rx);
    open_frame();
    for (int i = 47; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    close_frame();
  endtask : xfer48
endmodule : spi_host_model

// ---- dv/test_dac_serial_load_reset_control.sv ----
`timescale 1ns/1ns
module test_dac_serial_load_reset_control;
  localparam int N     = dac_front_pkg::NUM_CH;
  localparam int LIMIT = 90000;
  // ==========================================
  // Signals
  logic ref_clk, rst_b, clk_en, sclk, sync_n, sdi, sdo;
  logic load_outputs_n, hw_reset_n, reset_level_strap;
  logic frame_ready, daisy_mode;
  logic [N-1:0][15:0] input_code;
  logic [N-1:0][15:0] dac_code;
  // Reference model state
  logic [15:0] in_m [N];
  logic [15:0] dac_m [N];
  logic        pend [N];
  logic        daisy_m;
  int          rb_ch;
  logic [23:0] q [$];
  logic [23:0] rx24;
  logic [47:0] rx48;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic [3:0]  cmds [3] = '{dac_front_pkg::CMD_WRITE_IN,
                            dac_front_pkg::CMD_WRITE_LOAD,
                            dac_front_pkg::CMD_LOAD_MASK};

  dac_serial_front u_dut (
    .ref_clk           (ref_clk),
    .rst_b             (rst_b),
    .clk_en            (clk_en),
    .sclk              (sclk),
    .sync_n            (sync_n),
    .sdi               (sdi),
    .sdo               (sdo),
    .load_outputs_n    (load_outputs_n),
    .hw_reset_n        (hw_reset_n),
    .reset_level_strap (reset_level_strap),
    .frame_ready       (frame_ready),
    .daisy_mode        (daisy_mode),
    .input_code        (input_code),
    .dac_code          (dac_code)
  );
  spi_host_model u_host (
    .ref_clk (ref_clk),
    .sclk    (sclk),
    .sync_n  (sync_n),
    .sdi     (sdi),
    .sdo     (sdo)
  );

  always #2 ref_clk = ~ref_clk;

  // ==========================================
  // Checking
  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic check_val(input string nm, input logic [23:0] exp,
                           input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check_val
  task automatic check_codes();
    @(negedge ref_clk);
    for (int i = 0; i < N; i++) begin
      check_val("input_code", 24'(in_m[i]), 24'(input_code[i]));
      check_val("dac_code", 24'(dac_m[i]), 24'(dac_code[i]));
    end
    check_val("daisy_mode", 24'(daisy_m), 24'(daisy_mode));
  endtask : check_codes
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      stop_test();
    end
  end

  // ==========================================
  // Reference model
  task automatic set_all(input logic [15:0] v);
    for (int i = 0; i < N; i++) begin
      in_m[i]  = v;
      dac_m[i] = v;
      pend[i]  = 1'b0;
    end
    daisy_m = 1'b0;
    rb_ch   = -1;
  endtask : set_all
  task automatic load_pend();
    for (int i = 0; i < N; i++) begin
      if (pend[i]) dac_m[i] = in_m[i];
      pend[i] = 1'b0;
    end
  endtask : load_pend
  task automatic exec(input logic [23:0] w);
    int ch;
    ch = int'(w[19:16]);
    case (w[23:20])
      dac_front_pkg::CMD_WRITE_IN: begin
        in_m[ch] = w[15:0];
        if (load_outputs_n === 1'b0) dac_m[ch] = w[15:0];
        else pend[ch] = 1'b1;
      end
      dac_front_pkg::CMD_WRITE_LOAD: begin
        in_m[ch]  = w[15:0];
        dac_m[ch] = w[15:0];
        pend[ch]  = 1'b0;
      end
      dac_front_pkg::CMD_LOAD_MASK: begin
        for (int i = 0; i < N; i++) begin
          if (w[i] && pend[i]) begin
            dac_m[i] = in_m[i];
            pend[i]  = 1'b0;
          end
        end
      end
      dac_front_pkg::CMD_READBACK: rb_ch = ch;
      dac_front_pkg::CMD_DAISY: daisy_m = w[0];
      default: ;
    endcase
  endtask : exec
  task automatic send(input logic [23:0] w);
    u_host.xfer24(w, rx24);
    if (hw_reset_n !== 1'b0) exec(w);
    else if (q.size() < dac_front_pkg::FIFO_DEPTH) q.push_back(w);
  endtask : send
  function automatic logic [23:0] rand_word(input logic [3:0] c);
    return {c, 4'($urandom_range(7)), 16'($urandom)};
  endfunction : rand_word

  // ==========================================
  // Main sequence
  initial begin
    logic [23:0] w;
    logic [23:0] exp;
    int          ch;
    ref_clk           = 1'b0;
    rst_b             = 1'b0;
    clk_en            = 1'b1;
    load_outputs_n    = 1'b1;
    hw_reset_n        = 1'b1;
    reset_level_strap = 1'b0;
    ch = $urandom(45);
    set_all(dac_front_pkg::ZERO_CODE);
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge ref_clk);
    check_codes();
    check_val("frame_ready", 24'h000001, 24'(frame_ready));
    // Writes with load high stay pending, channel 0 among them
    for (int k = 0; k < 6; k++) begin
      w = rand_word(dac_front_pkg::CMD_WRITE_IN);
      if (k == 0) w[19:16] = 4'h0;
      send(w);
      check_codes();
    end
    @(posedge ref_clk);
    load_outputs_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    load_outputs_n <= 1'b1;
    load_pend();
    repeat (6) @(posedge ref_clk);
    check_codes();
    for (int k = 0; k < 8; k++) begin
      send(rand_word(cmds[$urandom_range(2)]));
      check_codes();
    end
    // Load held low
    @(posedge ref_clk);
    load_outputs_n <= 1'b0;
    load_pend();
    for (int k = 0; k < 3; k++) begin
      w = rand_word(dac_front_pkg::CMD_WRITE_IN);
      if (k == 0) w[19:16] = 4'h0;
      send(w);
      check_codes();
    end
    @(posedge ref_clk);
    load_outputs_n <= 1'b1;
    // Bits past the 24th are ignored
    w = rand_word(dac_front_pkg::CMD_WRITE_LOAD);
    u_host.xfer48({w, rand_word(dac_front_pkg::CMD_WRITE_LOAD)}, rx48);
    exec(w);
    check_codes();
    // Readback of input codes
    for (int k = 0; k < 4; k++) begin
      ch = $urandom_range(7);
      send({dac_front_pkg::CMD_READBACK, 4'(ch), 16'h0000});
      exp = {in_m[ch], 8'h00};
      send({dac_front_pkg::CMD_READBACK, 4'(ch ^ 1), 16'h0000});
      check_val("sdo", exp, rx24);
    end
    // Chain mode passes bits through
    send({dac_front_pkg::CMD_DAISY, 4'h0, 16'h0001});
    check_codes();
    exp = 24'($urandom);
    w = rand_word(dac_front_pkg::CMD_WRITE_LOAD);
    u_host.xfer48({exp, w}, rx48);
    exec(w);
    check_val("sdo", exp, rx48[23:0]);
    check_codes();
    send({dac_front_pkg::CMD_DAISY, 4'h0, 16'h0000});
    check_codes();
    // Reset pin to midscale, then queue while held low
    reset_level_strap <= 1'b1;
    repeat (4) @(posedge ref_clk);
    hw_reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    set_all(dac_front_pkg::MID_CODE);
    check_codes();
    reset_level_strap <= 1'b0;
    for (int k = 0; k < 9; k++) begin
      send({dac_front_pkg::CMD_WRITE_LOAD, 4'(k % 8), 16'($urandom)});
    end
    check_codes();
    check_val("frame_ready", 24'h000000, 24'(frame_ready));
    @(posedge ref_clk);
    hw_reset_n <= 1'b1;
    repeat (30) @(posedge ref_clk);
    while (q.size() > 0) exec(q.pop_front());
    check_codes();
    check_val("frame_ready", 24'h000001, 24'(frame_ready));
    // Reset pin to zero scale
    @(posedge ref_clk);
    hw_reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    set_all(dac_front_pkg::ZERO_CODE);
    check_codes();
    hw_reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    stop_test();
  end
endmodule : test_dac_serial_load_reset_control
